// ### dv/tks_panel_model.sv
// touch panel and reading-logic model for the key scanner
`timescale 1ns/10ps
`default_nettype none
module tks_panel_model #(
    parameter int unsigned COLS = 16
) (
    input  wire logic            phase_a_i,
    input  wire logic            phase_b_i,
    input  wire logic            touch_i,
    input  wire logic [5:0]      pad_i,
    input  wire logic [4:0]      code_oe_i,
    input  wire logic            flag_oe_i,
    output logic [COLS-1:0]      sense_o,
    output logic [4:0]           code_pin_o,
    output logic                 flag_pin_o
);
    ////////////////////////////////////////////////////////////////////
    // a touched pad damps only its own line, in its own scan phase
    always_comb
    begin
        sense_o = '0;
        if (touch_i && ((pad_i < 6'(COLS)) ? phase_a_i : phase_b_i))
        begin
            sense_o[pad_i % 6'(COLS)] = 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // released open-drain pins fall to the pull-down of the load
    assign code_pin_o = code_oe_i;
    assign flag_pin_o = flag_oe_i;
endmodule : tks_panel_model
`default_nettype wire

// ### dv/tks_scanner_test.sv
// self-checking bench for the touch key scanner
`timescale 1ns/10ps
`default_nettype none
module tks_scanner_test;
    localparam int unsigned HOLD = 240;
    // one row: pad touched and gate level
    typedef struct packed {logic [5:0] pad; logic gate;} tks_row_s;
    tks_row_s    rows [5] = '{'{0, 0}, '{5, 0}, '{15, 1}, '{16, 0}, '{30, 1}};
    logic        sys_clk_i = 1'b0;
    logic        reset_i   = 1'b1;
    logic        psel      = 1'b0;
    logic        penable   = 1'b0;
    logic        pwrite    = 1'b0;
    logic [11:0] paddr     = '0;
    logic [31:0] pwdata    = '0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        irq_o;
    logic [15:0] sense;
    logic        pa;
    logic        pb;
    logic        mode      = 1'b0;
    logic        gate      = 1'b0;
    logic        touch     = 1'b0;
    logic [5:0]  pad       = '0;
    logic [4:0]  code;
    logic [4:0]  code_oe;
    logic [4:0]  code_pin;
    logic        flag;
    logic        flag_oe;
    logic        flag_pin;
    logic [31:0] d;
    logic        e;
    int unsigned num_errors = 0;
    int unsigned n_checks   = 0;
    int unsigned cycles     = 0;
    int unsigned na, nb, nab;
    ////////////////////////////////////////////////////////////////////
    // design, fast oscillator and short delay
    tks_scanner #(.COLS(16), .OSC_DIV(8), .DELAY_TICKS(8)) dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq_o(irq_o), .sense_i(sense),
        .scan_phase_a_clock_o(pa), .scan_phase_b_clock_o(pb),
        .mode_toggle_i(mode), .output_gate_input_i(gate),
        .code_o(code), .code_oe_o(code_oe),
        .any_key_flag_o(flag), .any_key_flag_oe_o(flag_oe));
    // panel and pulled-down reading logic
    tks_panel_model #(.COLS(16)) panel (
        .phase_a_i(pa), .phase_b_i(pb), .touch_i(touch), .pad_i(pad),
        .code_oe_i(code_oe), .flag_oe_i(flag_oe), .sense_o(sense),
        .code_pin_o(code_pin), .flag_pin_o(flag_pin));
    ////////////////////////////////////////////////////////////////////
    // clock and hang guard
    always #4 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            num_errors++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task automatic wrap_up;
        if (num_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : wrap_up
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk
    task automatic wait_n(input int unsigned n);
        repeat (n) @(posedge sys_clk_i);
    endtask : wait_n
    // one apb transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] wd);
        @(posedge sys_clk_i);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= wd;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        @(posedge sys_clk_i);
        // only the bench timeout ends a wait for the answer
        while (pready !== 1'b1)
            @(posedge sys_clk_i);
        d = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, '0);
        chk(d, exp);
        chk(32'(e), 32'h0000_0000);
    endtask : rd
    // touch a pad for len cycles, then let go for rest cycles
    task automatic press(input logic [5:0] p, input int unsigned len,
                         input int unsigned rest);
        pad   <= p;
        touch <= 1'b1;
        wait_n(len);
        touch <= 1'b0;
        wait_n(rest);
    endtask : press
    ////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        wait_n(2);
        reset_i <= 1'b0;
        chk(32'(code), 32'h0000_001F);
        chk(32'({code_oe, flag, flag_oe, irq_o}), 32'h0000_0000);
        rd(tks_pkg::OFS_CTRL, 32'h0000_0001);
        rd(tks_pkg::OFS_INT_MSK, 32'h0000_0000);
        apb(1'b0, 12'h020, '0);
        chk({d[30:0], e}, 32'h0000_0001);
        // phases alternate and never overlap
        na = 0;
        nb = 0;
        nab = 0;
        repeat (64)
        begin
            @(posedge sys_clk_i);
            na += pa;
            nb += pb;
            nab += pa & pb;
        end
        chk(32'(nab), 32'h0000_0000);
        chk(32'((na > 0) && (nb > 0)), 32'h0000_0001);
        apb(1'b1, tks_pkg::OFS_CTRL, 32'h0000_0000);
        wait_n(24);
        chk(32'({pa, pb}), 32'h0000_0000);
        apb(1'b1, tks_pkg::OFS_CTRL, 32'h0000_0001);
        // momentary rows: code, flag and gate
        foreach (rows[i])
        begin
            gate  <= rows[i].gate;
            pad   <= rows[i].pad;
            touch <= 1'b1;
            wait_n(HOLD);
            chk(32'(code), 32'(rows[i].pad));
            chk(32'(flag), 32'h0000_0001);
            chk(32'(code_pin), rows[i].gate ? '0 : 32'(rows[i].pad));
            chk(32'(flag_pin), 32'(!rows[i].gate));
            touch <= 1'b0;
            wait_n(60);
            chk(32'({flag, code}), 32'h0000_001F);
        end
        gate <= 1'b0;
        // interrupt raised, cleared, masked
        apb(1'b1, tks_pkg::OFS_INT_MSK, 32'h0000_0001);
        wait_n(4);
        chk(32'(irq_o), 32'h0000_0001);
        apb(1'b1, tks_pkg::OFS_INT_STS, 32'h0000_0001);
        wait_n(4);
        chk(32'(irq_o), 32'h0000_0000);
        apb(1'b1, tks_pkg::OFS_INT_MSK, 32'h0000_0000);
        // brief touches, with a drop between, are ignored
        press(6'd7, 24, 16);
        press(6'd7, 24, 60);
        rd(tks_pkg::OFS_INT_STS, 32'h0000_0000);
        chk(32'(flag), 32'h0000_0000);
        // toggle mode latches, second touch releases
        mode <= 1'b1;
        wait_n(8);
        press(6'd3, HOLD, 60);
        chk(32'({flag, code}), 32'h0000_0023);
        rd(tks_pkg::OFS_LATCH, 32'h0000_0008);
        rd(tks_pkg::OFS_STATUS, 32'h0000_0303);
        press(6'd3, HOLD, 60);
        chk(32'({flag, code}), 32'h0000_001F);
        rd(tks_pkg::OFS_LATCH, 32'h0000_0000);
        press(6'd20, HOLD, 60);
        rd(tks_pkg::OFS_LATCH, 32'h0010_0000);
        // software clear empties the latches, then set one again
        apb(1'b1, tks_pkg::OFS_CTRL, 32'h0000_0003);
        rd(tks_pkg::OFS_LATCH, 32'h0000_0000);
        press(6'd20, HOLD, 60);
        rd(tks_pkg::OFS_LATCH, 32'h0010_0000);
        // mode pulse low clears latches and flags an event
        apb(1'b1, tks_pkg::OFS_INT_STS, 32'h0000_0003);
        apb(1'b1, tks_pkg::OFS_INT_MSK, 32'h0000_0002);
        mode <= 1'b0;
        wait_n(20);
        mode <= 1'b1;
        wait_n(10);
        rd(tks_pkg::OFS_LATCH, 32'h0000_0000);
        chk(32'({irq_o, flag, code}), 32'h0000_005F);
        apb(1'b1, tks_pkg::OFS_INT_STS, 32'h0000_0002);
        wait_n(4);
        chk(32'(irq_o), 32'h0000_0000);
        // mid-run reset restores control, mask and outputs
        apb(1'b1, tks_pkg::OFS_CTRL, 32'h0000_0000);
        reset_i <= 1'b1;
        wait_n(2);
        reset_i <= 1'b0;
        chk(32'({irq_o, flag, code, pa, pb}), 32'h0000_007C);
        rd(tks_pkg::OFS_CTRL, 32'h0000_0001);
        rd(tks_pkg::OFS_INT_MSK, 32'h0000_0000);
        wrap_up();
    end
endmodule : tks_scanner_test
`default_nettype wire

// ### verilog/tks_pkg.sv
// constants shared by the touch key scanner design
package tks_pkg;
    // clock and oscillator rates
    localparam int unsigned SYS_CLK_HZ         = 125_000_000;
    localparam int unsigned OSC_HZ             = 50_000;
    // scan divider: system cycles per oscillator period
    localparam int unsigned OSC_DIV            = SYS_CLK_HZ / OSC_HZ;
    // least touch time and longest latch clear time, in ms
    localparam int unsigned TOUCH_DELAY_MIN_MS = 65;
    localparam int unsigned CLEAR_MAX_MS       = 135;
    // least touch time in oscillator ticks, rounded up
    localparam int unsigned DELAY_TICKS        =
        (TOUCH_DELAY_MIN_MS * OSC_HZ + 999) / 1000;
    // default sense input count (16 gives 32 pads, 7 gives 14)
    localparam int unsigned SENSE_COLS         = 16;
    // register byte offsets
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_STATUS  = 12'h004;
    localparam logic [11:0] OFS_INT_STS = 12'h008;
    localparam logic [11:0] OFS_INT_MSK = 12'h00C;
    localparam logic [11:0] OFS_LATCH   = 12'h010;
    // control bit positions
    localparam int unsigned CTRL_SCAN_EN_BIT = 0;
    localparam int unsigned CTRL_CLEAR_BIT   = 1;
    // status bit positions above the code field
    localparam int unsigned STS_ANY_BIT      = 8;
    localparam int unsigned STS_TOGGLE_BIT   = 9;
    localparam int unsigned STS_HIT_BIT      = 10;
    // interrupt bit positions
    localparam int unsigned INT_PRESS_BIT    = 0;
    localparam int unsigned INT_CLEAR_BIT    = 1;
    // reset values
    localparam logic        CTRL_SCAN_EN_RST = 1'b1;
    localparam logic [1:0]  INT_MSK_RST      = 2'h0;
endpackage : tks_pkg

// ### verilog/tks_qual.sv
// touch qualifier: a candidate pad must persist for the switch delay
`timescale 1ns/10ps
`default_nettype none
module tks_qual #(
    parameter int unsigned CODE_W      = 5,
    parameter int unsigned DELAY_TICKS = tks_pkg::DELAY_TICKS
) (
    input  wire logic              sys_clk_i,
    input  wire logic              reset_i,
    input  wire logic              tick_i,
    input  wire logic              cand_vld_i,
    input  wire logic [CODE_W-1:0] cand_code_i,
    output logic                   hit_o,
    output logic [CODE_W-1:0]      code_o,
    output logic                   press_o
);
    localparam int unsigned CNT_W = $clog2(DELAY_TICKS + 1);

    // parameter check
    initial
    begin
        if (DELAY_TICKS < 1)
            $error("tks_qual: DELAY_TICKS must be at least one");
    end

    typedef struct packed {
        logic [CNT_W-1:0]  cnt;    // ticks the candidate has persisted
        logic [CODE_W-1:0] code;   // candidate being timed
        logic              hit;    // candidate qualified
        logic              press;  // one-cycle qualify pulse
    } tks_qual_s;

    tks_qual_s st_ff;
    tks_qual_s nxt_st;

    ////////////////////////////////////////////////////////////////////
    // next state: restart on drop or change, qualify at the delay
    always_comb
    begin
        nxt_st       = st_ff;
        nxt_st.press = 1'b0;
        if (!cand_vld_i || cand_code_i != st_ff.code)
        begin
            // brief or moving contact restarts the delay
            nxt_st.cnt  = '0;
            nxt_st.hit  = 1'b0;
            nxt_st.code = cand_code_i;
        end
        else if (tick_i && !st_ff.hit)
        begin
            if (st_ff.cnt == CNT_W'(DELAY_TICKS - 1))
            begin
                // touch persisted long enough
                nxt_st.hit   = 1'b1;
                nxt_st.press = 1'b1;
            end
            else
            begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
            st_ff <= '0;
        else
            st_ff <= nxt_st;
    end

    assign hit_o   = st_ff.hit;
    assign code_o  = st_ff.code;
    assign press_o = st_ff.press;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    AST_QUAL_AFTER_DELAY: assert property (
        $rose(st_ff.hit) |-> $past(st_ff.cnt) == CNT_W'(DELAY_TICKS - 1)
            && $past(tick_i))
        else $error("touch qualified before the full delay");
    AST_QUAL_RESTART: assert property (
        !cand_vld_i |=> st_ff.cnt == '0 && !st_ff.hit)
        else $error("delay not restarted on dropped touch");
    COV_QUAL_HIT: cover property ($rose(st_ff.hit));
endmodule : tks_qual
`default_nettype wire

// ### verilog/tks_scanner.sv
// multiplexed touch key scanner with apb registers and interrupt
// Summary of operation
// - mode input low gives momentary outputs
// - momentary: no touch gives none code (all ones), flag off
// - open mode input pulled low, so momentary
// - mode input high selects toggle mode
// - toggle: each valid touch inverts pad latch
// - mode low pulse clears all latches quickly
// - respond only after touch persists switch delay
// - one oscillator paces scan and delay
// - phase a drives first COLS pads (16 by default), b others
// - two rows times sense inputs form matrix
// - asserted output drives, unasserted is open drain
// - coded outputs name selected pad or none
// - any-key flag high while a pad selected
// - gate input high disables coded outputs, flag
`timescale 1ns/10ps
`default_nettype none
module tks_scanner #(
    parameter int unsigned COLS        = tks_pkg::SENSE_COLS,
    parameter int unsigned OSC_DIV     = tks_pkg::OSC_DIV,
    parameter int unsigned DELAY_TICKS = tks_pkg::DELAY_TICKS
) (
    input  wire logic                  sys_clk_i,
    input  wire logic                  reset_i,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    output logic                       irq_o,
    // panel side
    input  wire logic [COLS-1:0]       sense_i,
    output logic                       scan_phase_a_clock_o,
    output logic                       scan_phase_b_clock_o,
    input  wire logic                  mode_toggle_i,
    input  wire logic                  output_gate_input_i,
    // open-drain coded outputs and any-key flag
    output logic [((COLS > 8) ? 5 : 4)-1:0] code_o,
    output logic [((COLS > 8) ? 5 : 4)-1:0] code_oe_o,
    output logic                       any_key_flag_o,
    output logic                       any_key_flag_oe_o
);
    localparam int unsigned NPAD   = 2 * COLS;
    localparam int unsigned CODE_W = (COLS > 8) ? 5 : 4;
    localparam int unsigned DIV_W  = $clog2(OSC_DIV);
    localparam logic [CODE_W-1:0] CODE_NONE = '1;

    // parameter check
    initial
    begin
        if (!(COLS == 7 || COLS == 16) || OSC_DIV < 2)
            $error("tks_scanner: COLS must be 7 or 16, OSC_DIV >= 2");
    end

    ////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        logic [COLS-1:0]   sense_s1;  // sense synchroniser stage 1
        logic [COLS-1:0]   sense_s2;  // sense synchroniser stage 2
        logic              mode_s1;   // mode synchroniser stage 1
        logic              mode_s2;   // 1 = toggle mode
        logic              mode_d;    // mode one cycle earlier
        logic              gate_s1;   // gate synchroniser stage 1
        logic              gate_s2;   // 1 = outputs off
        logic [DIV_W-1:0]  div;       // oscillator divider
        logic              phase;     // 0 = phase a, 1 = phase b
        logic [NPAD-1:0]   frame;     // latest touch picture
        logic [NPAD-1:0]   latch;     // toggle latches
        logic              scan_en;   // software scan enable
        logic [1:0]        ists;      // sticky interrupt status
        logic [1:0]        imsk;      // interrupt mask
        logic [31:0]       prdata;
        logic              pready;
        logic              pslverr;
        logic              irq;
        logic              sc_a;
        logic              sc_b;
        logic [CODE_W-1:0] code;      // selected pad or none
        logic [CODE_W-1:0] code_oe;
        logic              akf;
        logic              akf_oe;
    } tks_scan_s;

    tks_scan_s st_ff;
    tks_scan_s nxt_st;

    // qualifier interface
    logic              tick;
    logic              cand_vld;
    logic [CODE_W-1:0] cand_code;
    logic              q_hit;
    logic [CODE_W-1:0] q_code;
    logic              q_press;
    logic              clr_evt;
    logic              wr_acc;

    // lowest set pad of a vector, valid bit on top
    function automatic logic [CODE_W:0] lowest(input logic [NPAD-1:0] v);
        logic [CODE_W:0] r;
        r = {1'b0, CODE_NONE};
        for (int i = NPAD - 1; i >= 0; i--)
        begin
            if (v[i])
                r = {1'b1, CODE_W'(i)};
        end
        return r;
    endfunction : lowest

    ////////////////////////////////////////////////////////////////////
    // candidate pad and oscillator tick
    always_comb
    begin
        tick = st_ff.scan_en && (st_ff.div == DIV_W'(OSC_DIV - 1));
        {cand_vld, cand_code} = lowest(st_ff.frame);
        wr_acc  = psel && penable && st_ff.pready && pwrite;
        clr_evt = (st_ff.mode_d && !st_ff.mode_s2)
            || (wr_acc && paddr == tks_pkg::OFS_CTRL
                && pwdata[tks_pkg::CTRL_CLEAR_BIT]);
    end

    // touch delay qualifier
    tks_qual #(
        .CODE_W      (CODE_W),
        .DELAY_TICKS (DELAY_TICKS)
    ) u_qual (
        .sys_clk_i   (sys_clk_i),
        .reset_i     (reset_i),
        .tick_i      (tick),
        .cand_vld_i  (cand_vld),
        .cand_code_i (cand_code),
        .hit_o       (q_hit),
        .code_o      (q_code),
        .press_o     (q_press)
    );

    ////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        logic [CODE_W:0] sel;
        logic [1:0]      ev;
        sel    = '0;
        ev     = '0;
        nxt_st = st_ff;

        // pin synchronisers; open mode pin reads low, so momentary
        nxt_st.sense_s1 = sense_i;
        nxt_st.sense_s2 = st_ff.sense_s1;
        nxt_st.mode_s1  = mode_toggle_i;
        nxt_st.mode_s2  = st_ff.mode_s1;
        nxt_st.mode_d   = st_ff.mode_s2;
        nxt_st.gate_s1  = output_gate_input_i;
        nxt_st.gate_s2  = st_ff.gate_s1;

        // divider and phase alternation, sampling a full row each phase
        nxt_st.div = tick ? '0 : DIV_W'(st_ff.div + 1'b1);
        if (!st_ff.scan_en)
            nxt_st.div = '0;
        if (tick)
        begin
            nxt_st.phase = !st_ff.phase;
            if (st_ff.phase)
                nxt_st.frame[NPAD-1:COLS] = st_ff.sense_s2;
            else
                nxt_st.frame[COLS-1:0] = st_ff.sense_s2;
        end
        // phase a drives the first row of pads, phase b the second
        nxt_st.sc_a = st_ff.scan_en && !nxt_st.phase;
        nxt_st.sc_b = st_ff.scan_en && nxt_st.phase;

        // toggle latches: invert on each qualified touch
        if (st_ff.mode_s2 && q_press)
            nxt_st.latch[q_code] = !st_ff.latch[q_code];
        if (!st_ff.mode_s2 || clr_evt)
            nxt_st.latch = '0;

        // selection: momentary follows touch, toggle uses latches
        if (st_ff.mode_s2)
            sel = lowest(st_ff.latch);
        else
            sel = {q_hit, q_hit ? q_code : CODE_NONE};
        nxt_st.code    = sel[CODE_W-1:0];
        nxt_st.akf     = sel[CODE_W];
        // asserted bit drives toward the rail, others float
        nxt_st.code_oe = st_ff.gate_s2 ? '0 : sel[CODE_W-1:0];
        nxt_st.akf_oe  = !st_ff.gate_s2 && sel[CODE_W];

        // apb: answer in the access cycle after each setup
        nxt_st.pready  = psel && !penable;
        nxt_st.pslverr = 1'b0;
        nxt_st.prdata  = '0;
        if (psel && !penable)
        begin
            unique case (paddr)
                tks_pkg::OFS_CTRL:
                    nxt_st.prdata[tks_pkg::CTRL_SCAN_EN_BIT] = st_ff.scan_en;
                tks_pkg::OFS_STATUS:
                begin
                    nxt_st.prdata[CODE_W-1:0]           = st_ff.code;
                    nxt_st.prdata[tks_pkg::STS_ANY_BIT] = st_ff.akf;
                    nxt_st.prdata[tks_pkg::STS_TOGGLE_BIT] = st_ff.mode_s2;
                    nxt_st.prdata[tks_pkg::STS_HIT_BIT] = q_hit;
                end
                tks_pkg::OFS_INT_STS: nxt_st.prdata[1:0]      = st_ff.ists;
                tks_pkg::OFS_INT_MSK: nxt_st.prdata[1:0]      = st_ff.imsk;
                tks_pkg::OFS_LATCH:   nxt_st.prdata[NPAD-1:0] = st_ff.latch;
                default:              nxt_st.pslverr          = 1'b1;
            endcase
        end
        if (wr_acc)
        begin
            if (paddr == tks_pkg::OFS_CTRL)
                nxt_st.scan_en = pwdata[tks_pkg::CTRL_SCAN_EN_BIT];
            if (paddr == tks_pkg::OFS_INT_STS)
                nxt_st.ists = st_ff.ists & ~pwdata[1:0];
            if (paddr == tks_pkg::OFS_INT_MSK)
                nxt_st.imsk = pwdata[1:0];
        end

        // events set sticky bits; a set beats a same-cycle clear
        ev[tks_pkg::INT_PRESS_BIT] = q_press;
        ev[tks_pkg::INT_CLEAR_BIT] = clr_evt;
        nxt_st.ists = nxt_st.ists | ev;
        nxt_st.irq  = |(nxt_st.ists & nxt_st.imsk);
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk_i)
    begin
        if (reset_i)
        begin
            st_ff         <= '0;
            st_ff.scan_en <= tks_pkg::CTRL_SCAN_EN_RST;
            st_ff.imsk    <= tks_pkg::INT_MSK_RST;
            st_ff.code    <= CODE_NONE;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign prdata               = st_ff.prdata;
    assign pready               = st_ff.pready;
    assign pslverr              = st_ff.pslverr;
    assign irq_o                = st_ff.irq;
    assign scan_phase_a_clock_o = st_ff.sc_a;
    assign scan_phase_b_clock_o = st_ff.sc_b;
    assign code_o               = st_ff.code;
    assign code_oe_o            = st_ff.code_oe;
    assign any_key_flag_o       = st_ff.akf;
    assign any_key_flag_oe_o    = st_ff.akf_oe;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);

    AST_MOMENTARY_FOLLOWS: assert property (
        (!st_ff.mode_s2 && q_hit) |=> st_ff.akf && st_ff.code == $past(q_code))
        else $error("momentary output does not follow the touch");
    AST_MOMENTARY_IDLE: assert property (
        (!st_ff.mode_s2 && !q_hit) |=> !st_ff.akf && st_ff.code == CODE_NONE)
        else $error("momentary output active with no touch");
    AST_TOGGLE_INVERTS: assert property (
        (st_ff.mode_s2 && q_press && !clr_evt)
            |=> st_ff.latch[$past(q_code)] != $past(st_ff.latch[q_code]))
        else $error("toggle latch not inverted by touch");
    AST_CLEAR_LATCHES: assert property (
        !st_ff.mode_s2 |=> st_ff.latch == '0)
        else $error("latches not cleared by mode pulse");
    AST_PHASE_ALTERNATES: assert property (
        tick |=> st_ff.phase != $past(st_ff.phase)
            && !(st_ff.sc_a && st_ff.sc_b))
        else $error("scan phase failed to alternate");
    AST_GATE_OFF: assert property (
        st_ff.gate_s2 |=> st_ff.code_oe == '0 && !st_ff.akf_oe)
        else $error("gated outputs still driven");
    AST_ANY_KEY: assert property (
        (st_ff.mode_s2 ? st_ff.latch != '0 : q_hit) |=> st_ff.akf
            && (NPAD == 32 || st_ff.code != CODE_NONE))
        else $error("any-key flag disagrees with code");
    AST_OPEN_DRAIN: assert property (
        !st_ff.gate_s2 |=> st_ff.code_oe == st_ff.code
            && st_ff.akf_oe == st_ff.akf)
        else $error("unasserted code bit driven");
    AST_APB_ANSWER: assert property (
        (psel && !penable) |=> st_ff.pready ##1 !st_ff.pready)
        else $error("apb answer not one access cycle");
    AST_IRQ_LEVEL: assert property (
        st_ff.irq == |(st_ff.ists & st_ff.imsk))
        else $error("interrupt not raised for unmasked status");

    COV_TOGGLE_PRESS: cover property (st_ff.mode_s2 && q_press);
    COV_MODE_CLEAR:   cover property (st_ff.mode_d && !st_ff.mode_s2);
    COV_GATED_KEY:    cover property (st_ff.gate_s2 && st_ff.akf);
endmodule : tks_scanner
`default_nettype wire
